// ==== gpio_port_pkg.sv ====
// Purpose: shared constants for the general purpose digital io port
// Assumes: 32-bit axi4-lite register bus, one aligned word per register
// Notes:   offsets are byte addresses

package gpio_port_pkg;

   // ***************************************************************
   // widths
   // ***************************************************************
   localparam int unsigned PINS_PER_PORT = 8;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 32;

   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam logic [ADDR_W-1:0] OFS_DIRECTION = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_OUTPUT    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_INPUT     = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_SPECIAL   = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_SENSE     = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CLEAR     = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_ENABLE    = 8'h1c;

   // ***************************************************************
   // fields and reset values
   // ***************************************************************
   localparam int unsigned PULLUP_DISABLE_POS = 2;
   localparam logic [7:0]  RST_DIRECTION      = 8'h00;
   localparam logic [7:0]  RST_OUTPUT         = 8'h00;
   localparam logic [7:0]  RST_SPECIAL        = 8'h00;
   localparam logic [7:0]  RST_SENSE          = 8'h00;
   localparam logic [7:0]  RST_STATUS         = 8'h00;
   localparam logic [7:0]  RST_ENABLE         = 8'h00;

   // ***************************************************************
   // bus responses
   // ***************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== pin_input_sync.sv ====
// Purpose: two stage pad input synchroniser, falling edge hold then rising edge load
// Assumes: pad levels are asynchronous to clk
// Notes:   the falling edge stage stands in for a latch open while clk is high

`timescale 1ns/1ps

module pin_input_sync
   import gpio_port_pkg::*;
#(
   parameter int unsigned WIDTH = PINS_PER_PORT
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] pad_level,
   output logic      [WIDTH-1:0] sync_level
);

   logic [WIDTH-1:0] hold_q;

   if (WIDTH < 1) begin : g_width_check
      $error("pin_input_sync: WIDTH must be at least 1");
   end

   // value seen at the falling edge is what an open latch would hold
   always_ff @(negedge clk) begin
      if (!rst_b) begin
         hold_q <= '0;
      end else begin
         hold_q <= pad_level;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sync_level <= '0;
      end else begin
         sync_level <= hold_q;
      end
   end

endmodule

// ==== pin_event_flags.sv ====
// Purpose: sticky per-pin change flags with enable mask and one level interrupt
// Assumes: level input already synchronised to clk
// Notes:   a new event beats a clear in the same cycle

`timescale 1ns/1ps

module pin_event_flags
   import gpio_port_pkg::*;
#(
   parameter int unsigned WIDTH = PINS_PER_PORT
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] level,
   input  wire logic [WIDTH-1:0] sense,
   input  wire logic [WIDTH-1:0] enable,
   input  wire logic [WIDTH-1:0] clear,
   output logic      [WIDTH-1:0] status_q,
   output logic                  irq
);

   logic [WIDTH-1:0] level_prev_q;
   logic [WIDTH-1:0] change;

   // the reset value constant is one byte wide
   if (WIDTH < 1 || WIDTH > 8) begin : g_width_check
      $error("pin_event_flags: WIDTH must be 1 to 8");
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         level_prev_q <= '0;
      end else begin
         level_prev_q <= level;
      end
   end

   // a clamp release after sleep shows up here as a rising change
   assign change = (level ^ level_prev_q) & sense;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         status_q <= RST_STATUS[WIDTH-1:0];
      end else begin
         status_q <= (status_q & ~clear) | change;
      end
   end

   assign irq = |(status_q & enable);

endmodule

// ==== gpio_port.sv ====
// Purpose: one eight pin general digital io port with axi4-lite registers
// Assumes: pad_in comes straight from the pad; sleep_clamp from the sleep controller on clk
// Notes:   reset gating of the drivers and pull-ups is combinational so it acts without clock

`timescale 1ns/1ps

// Behaviour
// - direction bit one makes the pin an output, zero an input
// - input with output bit one enables pull-up unless global disable set
// - output drives pad to output bit value; no pull-up while output
// - reset tri-states every pin at once, clock not needed
// - global pull-up disable kills all pull-ups; such input becomes tri-state
// - synchronised pad level readable in input bit regardless of direction
// - sync stage open with clock high, holds on fall, loads on rise
// - pad transitions appear in input bit after half to one and half periods
// - written output reaches input bit one period after latching edge
// - deep sleep clamps the digital input to ground ahead of buffer
// - clamp bypassed for pins whose external interrupt is enabled
// - clamp release sets flag of high, unenabled, edge triggered pin
// - pull-ups stay disabled throughout reset whatever output bits hold
// - global pull-up disable is bit 2 of special register, resets zero
module gpio_port
   import gpio_port_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [DATA_W-1:0]        s_axi_wdata,
   input  wire logic [DATA_W/8-1:0]      s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [ADDR_W-1:0]        s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [DATA_W-1:0]             s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // pads
   input  wire logic [PINS_PER_PORT-1:0] pad_in,
   output logic      [PINS_PER_PORT-1:0] pad_out,
   output logic      [PINS_PER_PORT-1:0] pad_oe,
   output logic      [PINS_PER_PORT-1:0] pullup_en,
   // system
   input  wire logic                     sleep_clamp,
   output logic                          irq
);

   // ***************************************************************
   // registers
   // ***************************************************************
   logic [PINS_PER_PORT-1:0] port_direction_reg_q;
   logic [PINS_PER_PORT-1:0] port_output_reg_q;
   logic [7:0]               special_function_ctrl_reg_q;
   logic [PINS_PER_PORT-1:0] edge_sense_q;
   logic [PINS_PER_PORT-1:0] ext_int_enable_q;
   logic [PINS_PER_PORT-1:0] port_input_reg;
   logic [PINS_PER_PORT-1:0] event_status;
   logic [PINS_PER_PORT-1:0] event_clear;
   logic                     global_pullup_disable;

   // ***************************************************************
   // bus handshake state
   // ***************************************************************
   logic                     bvalid_q;
   logic [1:0]               bresp_q;
   logic                     rvalid_q;
   logic [1:0]               rresp_q;
   logic [DATA_W-1:0]        rdata_q;
   logic                     wr_take;
   logic                     rd_take;
   logic                     wr_lane0;
   logic [PINS_PER_PORT-1:0] wr_byte;
   logic [PINS_PER_PORT-1:0] clamped_pad;

   function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
      unique case (addr)
         OFS_DIRECTION, OFS_OUTPUT, OFS_INPUT, OFS_SPECIAL,
         OFS_SENSE, OFS_STATUS, OFS_CLEAR, OFS_ENABLE: is_mapped = 1'b1;
         default:                                      is_mapped = 1'b0;
      endcase
   endfunction

   assign global_pullup_disable = special_function_ctrl_reg_q[PULLUP_DISABLE_POS];

   // ***************************************************************
   // pad drive
   // ***************************************************************
   // reset gates the enables directly so pins float even with no clock edge
   assign pad_oe    = port_direction_reg_q & {PINS_PER_PORT{rst_b}};
   assign pad_out   = port_output_reg_q;
   assign pullup_en = ~port_direction_reg_q & port_output_reg_q
                      & {PINS_PER_PORT{~global_pullup_disable}} & {PINS_PER_PORT{rst_b}};

   // ***************************************************************
   // input path
   // ***************************************************************
   // clamp ahead of the synchroniser; pins with an enabled interrupt stay live
   assign clamped_pad = sleep_clamp ? (pad_in & ext_int_enable_q) : pad_in;

   pin_input_sync #(
      .WIDTH      (PINS_PER_PORT)
   ) u_sync (
      .clk        (clk),
      .rst_b      (rst_b),
      .pad_level  (clamped_pad),
      .sync_level (port_input_reg)
   );

   pin_event_flags #(
      .WIDTH    (PINS_PER_PORT)
   ) u_flags (
      .clk      (clk),
      .rst_b    (rst_b),
      .level    (port_input_reg),
      .sense    (edge_sense_q),
      .enable   (ext_int_enable_q),
      .clear    (event_clear),
      .status_q (event_status),
      .irq      (irq)
   );

   // ***************************************************************
   // axi4-lite write
   // ***************************************************************
   // address and data are taken together; one response outstanding at most
   assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
   assign s_axi_awready = wr_take;
   assign s_axi_wready  = wr_take;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign wr_lane0      = wr_take & s_axi_wstrb[0];
   assign wr_byte       = s_axi_wdata[PINS_PER_PORT-1:0];
   assign event_clear   = (wr_lane0 && s_axi_awaddr == OFS_CLEAR) ? wr_byte : '0;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_take) begin
         bvalid_q <= 1'b1;
         bresp_q  <= is_mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // each register write only touches its own eight bits
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         port_direction_reg_q <= RST_DIRECTION;
      end else if (wr_lane0 && s_axi_awaddr == OFS_DIRECTION) begin
         port_direction_reg_q <= wr_byte;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         port_output_reg_q <= RST_OUTPUT;
      end else if (wr_lane0 && s_axi_awaddr == OFS_OUTPUT) begin
         port_output_reg_q <= wr_byte;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         special_function_ctrl_reg_q <= RST_SPECIAL;
      end else if (wr_lane0 && s_axi_awaddr == OFS_SPECIAL) begin
         special_function_ctrl_reg_q <= s_axi_wdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         edge_sense_q <= RST_SENSE;
      end else if (wr_lane0 && s_axi_awaddr == OFS_SENSE) begin
         edge_sense_q <= wr_byte;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ext_int_enable_q <= RST_ENABLE;
      end else if (wr_lane0 && s_axi_awaddr == OFS_ENABLE) begin
         ext_int_enable_q <= wr_byte;
      end
   end

   // ***************************************************************
   // axi4-lite read
   // ***************************************************************
   assign rd_take       = s_axi_arvalid & ~rvalid_q;
   assign s_axi_arready = rd_take;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= '0;
      end else if (rd_take) begin
         rvalid_q <= 1'b1;
         rresp_q  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr)
            OFS_DIRECTION: rdata_q <= {24'h000000, port_direction_reg_q};
            OFS_OUTPUT:    rdata_q <= {24'h000000, port_output_reg_q};
            OFS_INPUT:     rdata_q <= {24'h000000, port_input_reg};
            OFS_SPECIAL:   rdata_q <= {24'h000000, special_function_ctrl_reg_q};
            OFS_SENSE:     rdata_q <= {24'h000000, edge_sense_q};
            OFS_STATUS:    rdata_q <= {24'h000000, event_status};
            OFS_ENABLE:    rdata_q <= {24'h000000, ext_int_enable_q};
            default:       rdata_q <= '0;
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule

// ==== gpio_port_properties.sv ====
// Purpose: concurrent checks on pin drivers, pull-ups and bus answers
// Assumes: sees only the ports of the port block
// Notes:   the reset check runs without the reset disable on purpose

`timescale 1ns/1ps

module gpio_port_properties (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [7:0]  pad_out,
   input wire logic [7:0]  pad_oe,
   input wire logic [7:0]  pullup_en
);
   // ***************************************************************
   // helpers
   // ***************************************************************
   logic wr_hit;
   assign wr_hit = s_axi_awvalid && s_axi_awready;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence wr_taken;
      wr_hit;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   // ***************************************************************
   // properties
   // ***************************************************************
   reset_gates_pins_a: assert property (disable iff (1'b0)
      !rst_b |-> pad_oe == 8'h00 && pullup_en == 8'h00) else $error("pin active in reset");
   drive_by_write_a: assert property ($changed(pad_oe) |-> $past(wr_hit))
      else $error("direction moved without a write");
   value_by_write_a: assert property ($changed(pad_out) |-> $past(wr_hit))
      else $error("drive value moved without a write");
   pull_by_write_a: assert property ($changed(pullup_en) |-> $past(wr_hit))
      else $error("pull-up moved without a write");
   pull_source_a: assert property ((pullup_en & ~(pad_out & ~pad_oe)) == 8'h00)
      else $error("pull-up on a driven or low pin");
   write_answer_a: assert property (wr_taken |=> s_axi_bvalid)
      else $error("write response late");
   read_answer_a: assert property (rd_taken |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
      else $error("read answer late or wide");
   resp_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
endmodule

bind gpio_port gpio_port_properties props (.clk, .rst_b, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
   .pad_out, .pad_oe, .pullup_en);

// ==== gpio_pad_model.sv ====
// Purpose: resolves each pad level from drivers, outside sources and pull-ups
// Assumes: the bench never drives a pin that the port drives
// Notes:   an undriven pad wanders every cycle so a stale level never reads valid

`timescale 1ns/1ps

module gpio_pad_model (
   input  wire logic       clk,
   input  wire logic [7:0] pad_out,
   input  wire logic [7:0] pad_oe,
   input  wire logic [7:0] pullup_en,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic      [7:0] pad_level
);
   logic [7:0] float_q = 8'h00;
   always_ff @(posedge clk) begin
      float_q <= ~float_q;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad_oe[i]) pad_level[i] = pad_out[i];
         else if (ext_en[i]) pad_level[i] = ext_val[i];
         else if (pullup_en[i]) pad_level[i] = 1'b1;
         else pad_level[i] = float_q[i];
      end
   end
endmodule

// ==== testbench.sv ====
// Purpose: self-checking bench for the io port over axi4-lite
// Assumes: the pad model closes the loop from drivers back to pad_in
// Notes:   expected pin values worked out by hand from the pin table

`timescale 1ns/1ps

module testbench import gpio_port_pkg::*;;
   logic              clk, rst_b, sleep_clamp, irq;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp;
   logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]        pad_in, pad_out, pad_oe, pullup_en, ext_en, ext_val;
   logic [7:0]        ofs [6] = '{OFS_DIRECTION, OFS_OUTPUT, OFS_SPECIAL, OFS_SENSE,
                                  OFS_STATUS, OFS_ENABLE};
   int                mismatches = 0;
   int                num_checks = 0;

   gpio_port uut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out, .pad_oe, .pullup_en, .sleep_clamp, .irq);
   gpio_pad_model pads (.clk, .pad_out, .pad_oe, .pullup_en, .ext_en, .ext_val,
      .pad_level(pad_in));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ***************************************************************
   // bus tasks
   // ***************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // callers enter just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do @(posedge clk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      // bready stays high, so the response is taken at the edge it is seen
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      check(32'(s_axi_bresp), 32'(r));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      check(s_axi_rdata, d);
      check(32'(s_axi_rresp), 32'(r));
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #(4 * 5000);
      mismatches++;
      print_verdict();
   end

   // ***************************************************************
   // tests
   // ***************************************************************
   initial begin
      {rst_b, sleep_clamp, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {ext_en, ext_val} = '0;
      s_axi_wstrb = 4'hf;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      foreach (ofs[i]) rd(ofs[i], 32'h0, RESP_OKAY);
      rd(8'h20, 32'h0, RESP_SLVERR);
      wr(8'h20, 32'hff, RESP_SLVERR);
      rd(OFS_CLEAR, 32'h0, RESP_OKAY);
      wr(OFS_OUTPUT, 32'ha5, RESP_OKAY);
      check(32'(pullup_en), 32'ha5);
      wr(OFS_DIRECTION, 32'h0f, RESP_OKAY);
      check(32'(pad_oe), 32'h0f);
      check(32'(pad_out), 32'ha5);
      check(32'(pullup_en), 32'ha0);
      wr(OFS_SPECIAL, 32'h1 << PULLUP_DISABLE_POS, RESP_OKAY);
      check(32'(pullup_en), 32'h0);
      rd(OFS_SPECIAL, 32'h4, RESP_OKAY);
      wr(OFS_SPECIAL, 32'h0, RESP_OKAY);
      ext_en <= 8'h50;
      ext_val <= 8'h40;
      repeat (2) @(posedge clk);
      rd(OFS_INPUT, 32'he5, RESP_OKAY);
      ext_val <= 8'h50;
      rd(OFS_INPUT, 32'he5, RESP_OKAY);
      rd(OFS_INPUT, 32'hf5, RESP_OKAY);
      fork
         wr(OFS_OUTPUT, 32'ha4, RESP_OKAY);
         rd(OFS_INPUT, 32'hf5, RESP_OKAY);
      join
      rd(OFS_INPUT, 32'hf4, RESP_OKAY);
      wr(OFS_SENSE, 32'h10, RESP_OKAY);
      ext_val <= 8'h40;
      repeat (3) @(posedge clk);
      rd(OFS_STATUS, 32'h10, RESP_OKAY);
      check(32'(irq), 32'h0);
      wr(OFS_ENABLE, 32'h10, RESP_OKAY);
      check(32'(irq), 32'h1);
      ext_val <= 8'h50;
      wr(OFS_ENABLE, 32'h40, RESP_OKAY);
      check(32'(irq), 32'h0);
      wr(OFS_CLEAR, 32'h10, RESP_OKAY);
      rd(OFS_STATUS, 32'h0, RESP_OKAY);
      sleep_clamp <= 1'b1;
      repeat (3) @(posedge clk);
      rd(OFS_INPUT, 32'h40, RESP_OKAY);
      wr(OFS_CLEAR, 32'h10, RESP_OKAY);
      sleep_clamp <= 1'b0;
      repeat (3) @(posedge clk);
      rd(OFS_STATUS, 32'h10, RESP_OKAY);
      rst_b <= 1'b0;
      #1;
      check(32'(pad_oe), 32'h0);
      check(32'(pullup_en), 32'h0);
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(OFS_DIRECTION, 32'h0, RESP_OKAY);
      print_verdict();
   end
endmodule
